// *** core/lra_pkg.sv ***
// Constants and types shared by the display RAM write addressing block
package lra_pkg;

	// ------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0]  ADDR_CMD    = 8'h00;
	localparam logic [7:0]  ADDR_DATA   = 8'h04;
	localparam logic [7:0]  ADDR_STATUS = 8'h08;

	// ------------------------------------------------------------
	// Drive modes
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		MODE_1_4    = 2'b00,
		MODE_STATIC = 2'b01,
		MODE_1_2    = 2'b10,
		MODE_1_3    = 2'b11
	} lra_mode_t;

	// ------------------------------------------------------------
	// Command opcodes and field positions
	// ------------------------------------------------------------
	localparam logic [1:0]  OP_PTR   = 2'h0;
	localparam logic [1:0]  OP_MODE  = 2'h2;
	localparam logic [4:0]  OP_DEV   = 5'h18;
	localparam logic [4:0]  OP_BANK  = 5'h1e;
	localparam logic [3:0]  OP_BLINK = 4'he;
	localparam int          CMD_E    = 3;
	localparam int          CMD_B    = 2;
	localparam int          CMD_I    = 1;
	localparam int          CMD_O    = 0;
	localparam int          CMD_AB   = 2;

	// ------------------------------------------------------------
	// Pointer steps and geometry
	// ------------------------------------------------------------
	localparam logic [5:0]  STEP_STATIC = 6'h08;
	localparam logic [5:0]  STEP_1_2    = 6'h04;
	localparam logic [5:0]  STEP_1_3    = 6'h03;
	localparam logic [5:0]  STEP_1_4    = 6'h02;
	localparam int          NUM_COLS    = 32;
	localparam int          NUM_ROWS    = 4;
	localparam int          RAM_BITS    = NUM_COLS * NUM_ROWS;
	localparam logic [1:0]  BANK_ROW    = 2'h2;

	// ------------------------------------------------------------
	// Status field positions
	// ------------------------------------------------------------
	localparam int          ST_PTR   = 0;
	localparam int          ST_SUB   = 5;
	localparam int          ST_MODE  = 7;
	localparam int          ST_EN    = 9;
	localparam int          ST_BIAS  = 10;
	localparam int          ST_IBANK = 11;
	localparam int          ST_OBANK = 12;
	localparam int          ST_PIN   = 13;
	localparam int          ST_RATE  = 15;
	localparam int          ST_ALT   = 17;
	localparam int          ST_MATCH = 18;

	// ------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------
	localparam lra_mode_t   RST_MODE = MODE_STATIC;
	localparam logic [4:0]  RST_PTR  = 5'h00;
	localparam logic [1:0]  RST_SUB  = 2'h0;
	localparam logic [1:0]  RST_ROW  = 2'h0;

endpackage : lra_pkg

// *** core/lra_ram.sv ***
// Display RAM, 32 columns by 4 rows, bit-masked write, registered row read
`timescale 1ns/1ps
module lra_ram
(
	// Clock
	input  wire logic                          clock,
	input  wire logic                          reset,
	// Write port
	input  wire logic                          wr_en,
	input  wire logic [lra_pkg::RAM_BITS-1:0]  wr_mask,
	input  wire logic [lra_pkg::RAM_BITS-1:0]  wr_bits,
	// Row read port
	input  wire logic [1:0]                    rd_row,
	output logic      [lra_pkg::NUM_COLS-1:0]  rd_data
);

	// ------------------------------------------------------------
	// Storage, bit index is column * 4 + row; left uninitialised
	// ------------------------------------------------------------
	logic [lra_pkg::RAM_BITS-1:0] mem_reg;
	logic [lra_pkg::NUM_COLS-1:0] row_bits;

	always_ff @(posedge clock)
	begin
		if (wr_en)
		begin
			mem_reg <= (mem_reg & ~wr_mask) | (wr_bits & wr_mask);
		end
	end

	// ------------------------------------------------------------
	// Row gather and read register
	// ------------------------------------------------------------
	always_comb
	begin
		row_bits = '0;
		for (int c = 0; c < lra_pkg::NUM_COLS; c++)
		begin
			row_bits[c] = mem_reg[{5'(c), rd_row}];
		end
	end

	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			rd_data <= '0;
		end
		else
		begin
			rd_data <= row_bits;
		end
	end

endmodule : lra_ram

// *** core/lra_top.sv ***
// Display RAM write addressing, bank selection and row fetch with AHB-Lite
`timescale 1ns/1ps
module lra_top
(
	// Clock and reset
	input  wire logic         clock,
	input  wire logic         reset,
	// AHB-Lite slave
	input  wire logic         hsel,
	input  wire logic [31:0]  haddr,
	input  wire logic [1:0]   htrans,
	input  wire logic         hwrite,
	input  wire logic [2:0]   hsize,
	input  wire logic [31:0]  hwdata,
	input  wire logic         hready,
	output logic              hreadyout,
	output logic              hresp,
	output logic      [31:0]  hrdata,
	// Pins
	input  wire logic         subaddr_pin_lsb,
	input  wire logic         subaddr_pin_msb,
	input  wire logic         disp_clk,
	// Display register and configuration
	output logic      [31:0]  segment_output,
	output logic      [1:0]   backplane_sel,
	output logic      [1:0]   drive_mode,
	output logic              bias_half,
	output logic              display_enable,
	output logic      [1:0]   blink_rate_field,
	output logic              alt_bank_blink_bit
);

	// ------------------------------------------------------------
	// Mode functions
	// ------------------------------------------------------------
	function automatic logic [5:0] lra_step(input lra_pkg::lra_mode_t m);
		case (m)
			lra_pkg::MODE_STATIC: lra_step = lra_pkg::STEP_STATIC;
			lra_pkg::MODE_1_2:    lra_step = lra_pkg::STEP_1_2;
			lra_pkg::MODE_1_3:    lra_step = lra_pkg::STEP_1_3;
			default:              lra_step = lra_pkg::STEP_1_4;
		endcase
	endfunction : lra_step

	// Column offset and row for the m-th bit counted from the MSB
	function automatic logic [4:0] lra_place(input lra_pkg::lra_mode_t md,
		input logic [2:0] m);
		case (md)
			lra_pkg::MODE_STATIC: lra_place = {m, 2'h0};
			lra_pkg::MODE_1_2:    lra_place = {m >> 1, 1'b0, m[0]};
			lra_pkg::MODE_1_3:    lra_place = {3'(m / 3), 2'(m % 3)};
			default:              lra_place = {2'h0, m[2], m[1:0]};
		endcase
	endfunction : lra_place

	// Last multiplex phase of a mode
	function automatic logic [1:0] lra_last(input lra_pkg::lra_mode_t m);
		case (m)
			lra_pkg::MODE_STATIC: lra_last = 2'h0;
			lra_pkg::MODE_1_2:    lra_last = 2'h1;
			lra_pkg::MODE_1_3:    lra_last = 2'h2;
			default:              lra_last = 2'h3;
		endcase
	endfunction : lra_last

	// Bank switching exists only in static and 1:2
	function automatic logic lra_banked(input lra_pkg::lra_mode_t m);
		lra_banked = (m == lra_pkg::MODE_STATIC) || (m == lra_pkg::MODE_1_2);
	endfunction : lra_banked

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	lra_pkg::lra_mode_t mode_reg;
	logic [4:0]         ptr_reg;
	logic [1:0]         sub_reg;
	logic               in_bank_reg;
	logic               out_bank_reg;
	logic               enable_reg;
	logic               bias_reg;
	logic [1:0]         rate_reg;
	logic               alt_reg;
	logic               dph_write_reg;
	logic [7:0]         dph_addr_reg;
	logic [1:0]         pin_s1_reg;
	logic [1:0]         pin_reg;
	logic [2:0]         dclk_reg;
	logic [1:0]         phase_reg;
	logic [1:0]         row_sel_reg;
	logic [1:0]         fetch_reg;
	logic [1:0]         fetch_bp_reg;
	logic [lra_pkg::NUM_COLS-1:0] rd_data;

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	wire        addr_ok    = (haddr[31:8] == 24'h000000);
	wire        bus_take   = hsel & hready & htrans[1];
	wire        take_write = bus_take & hwrite & addr_ok;
	wire        take_read  = bus_take & ~hwrite;
	wire        wr_cmd     = dph_write_reg &
		(dph_addr_reg == lra_pkg::ADDR_CMD);
	wire        wr_data    = dph_write_reg &
		(dph_addr_reg == lra_pkg::ADDR_DATA);
	wire [7:0]  cmd        = hwdata[7:0];

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	wire is_ptr   = wr_cmd & (cmd[6:5] == lra_pkg::OP_PTR);
	wire is_mode  = wr_cmd & (cmd[6:5] == lra_pkg::OP_MODE);
	wire is_dev   = wr_cmd & (cmd[6:2] == lra_pkg::OP_DEV);
	wire is_bank  = wr_cmd & (cmd[6:2] == lra_pkg::OP_BANK) &
		lra_banked(mode_reg);
	wire is_blink = wr_cmd & (cmd[6:3] == lra_pkg::OP_BLINK);

	// ------------------------------------------------------------
	// Pointer advance and subaddress match
	// ------------------------------------------------------------
	wire [5:0] ptr_sum  = {1'b0, ptr_reg} + lra_step(mode_reg);
	wire       ptr_ovf  = ptr_sum[5];
	wire       sub_hit  = (sub_reg == pin_reg);
	wire       ram_we   = wr_data & sub_hit;
	wire       in_eff   = in_bank_reg & lra_banked(mode_reg);
	wire       out_eff  = out_bank_reg & lra_banked(mode_reg);
	wire [1:0] in_base  = in_eff ? lra_pkg::BANK_ROW : 2'h0;
	wire [1:0] out_base = out_eff ? lra_pkg::BANK_ROW : 2'h0;

	// ------------------------------------------------------------
	// Filling order, one mask bit per placed byte bit
	// ------------------------------------------------------------
	logic [lra_pkg::RAM_BITS-1:0] wr_mask;
	logic [lra_pkg::RAM_BITS-1:0] wr_bits;

	always_comb
	begin
		logic [4:0] pl;
		logic [4:0] col;
		logic [1:0] row;
		pl = 5'h00;
		col = 5'h00;
		row = 2'h0;
		wr_mask = '0;
		wr_bits = '0;
		for (int m = 0; m < 8; m++)
		begin
			pl = lra_place(mode_reg, 3'(m));
			col = ptr_reg + {2'h0, pl[4:2]};
			row = pl[1:0] + in_base;
			wr_mask[{col, row}] = 1'b1;
			wr_bits[{col, row}] = cmd[7 - m];
		end
	end

	// ------------------------------------------------------------
	// Display clock edge and multiplex phase
	// ------------------------------------------------------------
	wire       dclk_rise  = dclk_reg[1] & ~dclk_reg[2];
	wire [1:0] phase_next = (phase_reg >= lra_last(mode_reg)) ?
		2'h0 : phase_reg + 2'h1;

	wire [31:0] status_word = {13'h0000,
		sub_hit, alt_reg, rate_reg, pin_reg, out_bank_reg,
		in_bank_reg, bias_reg, enable_reg, mode_reg, sub_reg, ptr_reg};

	// ------------------------------------------------------------
	// Bus slave registers
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			dph_write_reg <= 1'b0;
			dph_addr_reg <= 8'h00;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			hrdata <= 32'h00000000;
		end
		else
		begin
			dph_write_reg <= take_write;
			dph_addr_reg <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			if (take_read)
			begin
				hrdata <= (addr_ok &&
					haddr[7:0] == lra_pkg::ADDR_STATUS) ?
					status_word : 32'h00000000;
			end
		end
	end

	// ------------------------------------------------------------
	// Addressing state
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			ptr_reg <= lra_pkg::RST_PTR;
			sub_reg <= lra_pkg::RST_SUB;
		end
		else if (is_ptr)
		begin
			ptr_reg <= cmd[4:0];
		end
		else if (is_dev)
		begin
			sub_reg <= cmd[1:0];
		end
		else if (wr_data)
		begin
			ptr_reg <= ptr_sum[4:0];
			sub_reg <= sub_reg + {1'b0, ptr_ovf};
		end
	end

	// ------------------------------------------------------------
	// Configuration state
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			mode_reg <= lra_pkg::RST_MODE;
			enable_reg <= 1'b0;
			bias_reg <= 1'b0;
			in_bank_reg <= 1'b0;
			out_bank_reg <= 1'b0;
			rate_reg <= 2'h0;
			alt_reg <= 1'b0;
		end
		else
		begin
			if (is_mode)
			begin
				mode_reg <= lra_pkg::lra_mode_t'(cmd[1:0]);
				enable_reg <= cmd[lra_pkg::CMD_E];
				bias_reg <= cmd[lra_pkg::CMD_B];
			end
			if (is_bank)
			begin
				in_bank_reg <= cmd[lra_pkg::CMD_I];
				out_bank_reg <= cmd[lra_pkg::CMD_O];
			end
			if (is_blink)
			begin
				alt_reg <= cmd[lra_pkg::CMD_AB];
				rate_reg <= cmd[1:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			pin_s1_reg <= 2'h0;
			pin_reg <= 2'h0;
			dclk_reg <= 3'h0;
		end
		else
		begin
			pin_s1_reg <= {subaddr_pin_msb, subaddr_pin_lsb};
			pin_reg <= pin_s1_reg;
			dclk_reg <= {dclk_reg[1:0], disp_clk};
		end
	end

	// ------------------------------------------------------------
	// Row fetch for the display register
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			phase_reg <= lra_pkg::RST_ROW;
			row_sel_reg <= lra_pkg::RST_ROW;
			fetch_reg <= 2'h0;
			fetch_bp_reg <= 2'h0;
		end
		else
		begin
			fetch_reg <= {fetch_reg[0], dclk_rise};
			if (dclk_rise)
			begin
				phase_reg <= phase_next;
				row_sel_reg <= phase_next + out_base;
				fetch_bp_reg <= phase_next;
			end
		end
	end

	// ------------------------------------------------------------
	// Display register outputs
	// ------------------------------------------------------------
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
		begin
			segment_output <= 32'h00000000;
			backplane_sel <= 2'h0;
			drive_mode <= lra_pkg::RST_MODE;
			bias_half <= 1'b0;
			display_enable <= 1'b0;
			blink_rate_field <= 2'h0;
			alt_bank_blink_bit <= 1'b0;
		end
		else
		begin
			if (fetch_reg[1])
			begin
				segment_output <= enable_reg ? rd_data : '0;
				backplane_sel <= fetch_bp_reg;
			end
			else if (!enable_reg)
			begin
				segment_output <= '0;
			end
			drive_mode <= mode_reg;
			bias_half <= bias_reg;
			display_enable <= enable_reg;
			blink_rate_field <= rate_reg;
			alt_bank_blink_bit <= alt_reg;
		end
	end

	// ------------------------------------------------------------
	// Display RAM, contents undefined until written
	// ------------------------------------------------------------
	lra_ram u_ram
	(
		.clock   (clock),
		.reset   (reset),
		.wr_en   (ram_we),
		.wr_mask (wr_mask),
		.wr_bits (wr_bits),
		.rd_row  (row_sel_reg),
		.rd_data (rd_data)
	);

endmodule : lra_top

// *** sim/lra_pin_model.sv ***
// Subaddress pins and free running display clock
`timescale 1ns/1ps
module lra_pin_model
(
	// Clock and bus activity
	input wire logic       clock,
	input wire logic       hsel,
	// Requested subaddress
	input wire logic [1:0] sub_req,
	// Pins
	output logic           subaddr_pin_lsb,
	output logic           subaddr_pin_msb,
	output logic           disp_clk
);
	initial
	begin
		disp_clk = 1'b0;
		{subaddr_pin_msb, subaddr_pin_lsb} = 2'h0;
		#3;
		forever #62.5 disp_clk = ~disp_clk;
	end

	// Pins move only while no transfer is selected
	always @(posedge clock)
		if (!hsel)
			{subaddr_pin_msb, subaddr_pin_lsb} <= sub_req;
endmodule : lra_pin_model

// *** sim/lra_properties.sv ***
// Checker for the display RAM addressing block
`timescale 1ns/1ps
module lra_checker
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        reset,
	// Bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	// Display
	input wire logic [31:0] segment_output,
	input wire logic [1:0]  backplane_sel,
	input wire logic [1:0]  drive_mode,
	input wire logic        display_enable
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (reset);

	wire taken = hsel && hready && htrans[1];
	wire cmd_addr = haddr == {24'h0, lra_pkg::ADDR_CMD};
	wire [2:0] rows = drive_mode == lra_pkg::MODE_STATIC ? 3'h1 :
		drive_mode == lra_pkg::MODE_1_2 ? 3'h2 :
		drive_mode == lra_pkg::MODE_1_3 ? 3'h3 : 3'h4;
	logic [4:0] mode_age;

	// Cycles since the drive mode last changed
	always_ff @(posedge clock or posedge reset)
	begin
		if (reset)
			mode_age <= 5'h00;
		else if ($changed(drive_mode))
			mode_age <= 5'h00;
		else if (mode_age != 5'h1f)
			mode_age <= mode_age + 5'h01;
	end

	sequence s_cmd_taken;
		taken && hwrite && cmd_addr;
	endsequence
	sequence s_mode_set;
		s_cmd_taken ##1 hwdata[6:5] == 2'h2;
	endsequence

	property p_mode_load;
		s_mode_set |-> ##2 drive_mode == $past(hwdata[1:0], 2);
	endproperty
	property p_enable_load;
		s_mode_set |-> ##2 display_enable == $past(hwdata[3], 2);
	endproperty
	property p_mode_cause;
		$changed(drive_mode) |-> $past(hwdata[6:5], 2) == 2'h2 &&
			$past(cmd_addr, 3);
	endproperty
	property p_ready;
		hreadyout;
	endproperty
	property p_okay;
		!hresp;
	endproperty
	property p_blank;
		!display_enable && !$past(display_enable) && !$past(display_enable, 2)
			|-> segment_output == 32'h0;
	endproperty
	property p_row_range;
		mode_age == 5'h1f |-> {1'b0, backplane_sel} < rows;
	endproperty
	property p_row_step;
		$changed(backplane_sel) && mode_age > 5'h03 |-> backplane_sel == 2'h0 ||
			backplane_sel == $past(backplane_sel) + 2'h1;
	endproperty
	property p_rdata_hold;
		!$past(taken && !hwrite) |-> $stable(hrdata);
	endproperty

	a_mode_load: assert property (p_mode_load)
		else $error("drive mode not loaded by mode-set");
	a_enable_load: assert property (p_enable_load)
		else $error("display enable not loaded by mode-set");
	a_mode_cause: assert property (p_mode_cause)
		else $error("drive mode changed without mode-set");
	a_ready: assert property (p_ready)
		else $error("wait state inserted");
	a_okay: assert property (p_okay)
		else $error("error response given");
	a_blank: assert property (p_blank)
		else $error("segments driven while display disabled");
	a_row_range: assert property (p_row_range)
		else $error("row out of range for drive mode");
	a_row_step: assert property (p_row_step)
		else $error("row sequence out of order");
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read data changed without read");
endmodule : lra_checker

bind lra_top lra_checker u_checker (.clock, .reset, .hsel, .haddr, .htrans,
	.hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .segment_output,
	.backplane_sel, .drive_mode, .display_enable);

// *** sim/testbench.sv ***
// Self-checking testbench for the display RAM addressing block
`timescale 1ns/1ps
module testbench;
	logic        clock, reset, hsel, hwrite;
	logic [31:0] haddr, hwdata;
	logic [1:0]  htrans, sub_req;
	wire         hready, hresp, sa_lsb, sa_msb, disp_clk;
	wire  [31:0] hrdata, segment_output;
	wire  [1:0]  backplane_sel, blink_rate_field;
	wire         bias_half, alt_bank_blink_bit;
	int          miscompares = 0;
	int          samples_checked = 0;
	int          cycles = 0;

	lra_top u_dut (.clock, .reset, .hsel, .haddr, .htrans, .hwrite,
		.hsize(3'h2), .hwdata, .hready, .hreadyout(hready), .hresp, .hrdata,
		.subaddr_pin_lsb(sa_lsb), .subaddr_pin_msb(sa_msb), .disp_clk,
		.segment_output, .backplane_sel, .drive_mode(), .bias_half,
		.display_enable(), .blink_rate_field, .alt_bank_blink_bit);
	lra_pin_model u_pins (.clock, .hsel, .sub_req, .subaddr_pin_lsb(sa_lsb),
		.subaddr_pin_msb(sa_msb), .disp_clk);

	// ----
	// Bus and checking tasks
	// ----
	task automatic check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic bus(input logic w, input logic [7:0] a, d,
		output logic [31:0] rd);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do @(posedge clock); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		do @(posedge clock); while (hready !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic cmd(input logic [7:0] d);
		logic [31:0] x;
		bus(1'b1, lra_pkg::ADDR_CMD, d, x);
	endtask : cmd

	task automatic dat(input logic [7:0] d, input int n);
		logic [31:0] x;
		repeat (n) bus(1'b1, lra_pkg::ADDR_DATA, d, x);
	endtask : dat

	task automatic status(output logic [31:0] s);
		bus(1'b0, lra_pkg::ADDR_STATUS, 8'h00, s);
	endtask : status

	task automatic select(input logic [1:0] a, input logic [4:0] p);
		cmd({6'h18, a});
		cmd({3'h0, p});
	endtask : select

	task automatic wait_seg(input logic [1:0] row, input logic [31:0] exp);
		int n;
		n = 0;
		while (n < 400 && !(backplane_sel === row && segment_output === exp))
		begin
			@(posedge clock);
			n++;
		end
		check("segment_output", segment_output, exp);
	endtask : wait_seg

	// ----
	// Scenarios
	// ----
	task automatic t_bus;
		logic [31:0] s;
		bus(1'b0, 8'h0c, 8'h00, s);
		check("unmapped read", s, 32'h0);
		bus(1'b0, lra_pkg::ADDR_CMD, 8'h00, s);
		check("command read", s, 32'h0);
		status(s);
		check("status after reset", s & 32'h1fff, 32'h80);
		cmd(8'h00);
		cmd(8'h45);
		cmd(8'h00);
		cmd(8'h60);
		cmd(8'h78);
		cmd(8'h74);
		repeat (3) @(posedge clock);
		check("bias_half", bias_half, 1'b1);
		check("alt_bank_blink_bit", alt_bank_blink_bit, 1'b1);
		check("blink_rate_field", blink_rate_field, 2'h0);
		cmd(8'h72);
		repeat (3) @(posedge clock);
		check("blink_rate_field", blink_rate_field, 2'h2);
		$display("t_bus done");
	endtask : t_bus

	task automatic t_steps;
		logic [1:0]  md [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
		logic [5:0]  st [4] = '{6'h8, 6'h4, 6'h3, 6'h2};
		logic [31:0] s;
		logic [5:0]  nxt;
		for (int i = 0; i < 4; i++)
		begin
			cmd({6'h10, md[i]});
			select(2'h0, 5'h1c);
			dat(8'h00, 1);
			nxt = 6'h1c + st[i];
			status(s);
			check("pointer step", s[8:0], {md[i], 1'b0, nxt});
		end
		$display("t_steps done");
	endtask : t_steps

	task automatic t_static;
		logic [7:0]  b [4] = '{8'h5a, 8'h0f, 8'hc3, 8'h81};
		logic [31:0] s, e;
		sub_req <= 2'h1;
		cmd(8'h49);
		cmd(8'h78);
		select(2'h1, 5'h00);
		for (int k = 0; k < 4; k++)
		begin
			dat(b[k], 1);
			for (int m = 0; m < 8; m++)
				e[8 * k + m] = b[k][7 - m];
		end
		cmd(8'h00);
		dat(8'hff, 1);
		status(s);
		check("discard step", s[6:0], 7'h48);
		wait_seg(2'h0, e);
		cmd(8'h41);
		wait_seg(2'h0, 32'h0);
		$display("t_static done");
	endtask : t_static

	task automatic t_banks;
		logic [31:0] s;
		cmd(8'h4a);
		cmd(8'h78);
		select(2'h1, 5'h00);
		dat(8'haa, 8);
		cmd(8'h7a);
		select(2'h1, 5'h00);
		dat(8'h55, 8);
		wait_seg(2'h0, 32'hffffffff);
		wait_seg(2'h1, 32'h0);
		cmd(8'h7b);
		wait_seg(2'h0, 32'h0);
		wait_seg(2'h1, 32'hffffffff);
		cmd(8'h48);
		cmd(8'h78);
		status(s);
		check("bank bits", s[12:11], 2'h3);
		$display("t_banks done");
	endtask : t_banks

	task automatic t_third;
		select(2'h1, 5'h00);
		dat(8'h00, 16);
		cmd(8'h4b);
		select(2'h1, 5'h00);
		dat(8'hff, 1);
		wait_seg(2'h0, 32'h7);
		wait_seg(2'h2, 32'h3);
		select(2'h1, 5'h02);
		dat(8'hff, 1);
		wait_seg(2'h2, 32'hf);
		wait_seg(2'h0, 32'h1f);
		$display("t_third done");
	endtask : t_third

	task automatic give_verdict;
		$display("samples_checked %0d miscompares %0d", samples_checked,
			miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict

	// ----
	// Clock, timeout and main sequence
	// ----
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	always @(posedge clock)
	begin
		cycles <= cycles + 1;
		if (cycles == 30000)
		begin
			miscompares++;
			give_verdict();
		end
	end

	initial
	begin
		reset = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		sub_req = 2'h0;
		repeat (5) @(posedge clock);
		reset <= 1'b0;
		t_bus();
		t_steps();
		t_static();
		t_banks();
		t_third();
		give_verdict();
	end
endmodule : testbench
